// File: common/swc_pkg.sv
package swc_pkg;

    // Register byte offsets
    localparam logic [11:0] SWC_OFF_CTRL   = 12'h000;
    localparam logic [11:0] SWC_OFF_STATUS = 12'h004;
    localparam logic [11:0] SWC_OFF_WAKEEN = 12'h008;
    localparam logic [11:0] SWC_OFF_IRQST  = 12'h00C;
    localparam logic [11:0] SWC_OFF_IRQMSK = 12'h010;
    localparam logic [11:0] SWC_OFF_LATCH  = 12'h014;

    // Status field positions
    localparam int SWC_ST_PD     = 3;
    localparam int SWC_ST_TO     = 4;
    localparam int SWC_ST_ASLEEP = 0;
    localparam int SWC_ST_GIE    = 1;

    // Control field positions
    localparam int SWC_CTL_WDTEN = 0;
    localparam int SWC_CTL_GIE   = 1;

    // Interrupt status bits
    localparam int SWC_IRQ_ENTER = 0;
    localparam int SWC_IRQ_WAKE  = 1;
    localparam int SWC_IRQ_NOP   = 2;
    localparam int SWC_IRQ_W     = 3;

    // Wake source count: ext pin, port change, eight peripherals
    localparam int SWC_NSRC = 10;

    // Reset values
    localparam logic [31:0] SWC_CTRL_RST   = 32'h0000_0001;
    localparam logic [31:0] SWC_WAKEEN_RST = 32'h0000_0000;

    // Oscillator restart time and its cycle count at 250 MHz
    localparam int SWC_RESTART_NS = 40;
    localparam int SWC_CLK_NS     = 4;
    localparam int SWC_RESTART_CYC = (SWC_RESTART_NS + SWC_CLK_NS - 1) / SWC_CLK_NS;

    // Interrupt vector
    localparam logic [12:0] SWC_INT_VECTOR = 13'h0004;

    typedef enum logic [1:0] {
        SWC_RUN,
        SWC_SLEEP,
        SWC_RESTART,
        SWC_RESUME
    } swc_state_t;

endpackage

// File: common/swc_wake_if.sv
`timescale 1ns/1ps
interface swc_wake_if;
    logic [swc_pkg::SWC_NSRC-1:0] flags;
    logic [swc_pkg::SWC_NSRC-1:0] enables;
    logic                         pending;

    modport src
    (
        output flags,
        output enables,
        input  pending
    );
    modport dst
    (
        input  flags,
        input  enables,
        output pending
    );
endinterface

// File: rtl/swc_wake_sources.sv
`timescale 1ns/1ps
module swc_wake_sources
    import swc_pkg::*;
(
    swc_wake_if.dst wk
);
    // A source wakes only when its own enable is set, whatever the global enable
    assign wk.pending = |(wk.flags & wk.enables);
endmodule

// File: rtl/swc_restart_timer.sv
`timescale 1ns/1ps
module swc_restart_timer
    import swc_pkg::*;
#(
    parameter int CYCLES = SWC_RESTART_CYC
)
(
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic start,
    output logic      done
);
    localparam int W = $clog2(CYCLES + 1);
    localparam logic [W-1:0] LOAD = W'(CYCLES);
    localparam logic [W-1:0] ONE  = W'(1);
    logic [W-1:0] count;
    logic         busy;

    // Oscillator settle count before execution resumes
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            count <= '0;
            busy  <= 1'b0;
        end
        else if (start)
        begin
            count <= LOAD;
            busy  <= 1'b1;
        end
        else if (busy)
        begin
            count <= count - ONE;
            busy  <= (count != ONE);
        end
    end

    assign done = busy && (count == ONE);
endmodule

// File: rtl/swc_sleep_wake_control.sv
`timescale 1ns/1ps
module swc_sleep_wake_control
    import swc_pkg::*;
#(
    parameter int PORT_W = 8
)
(
    input  wire logic                clk,
    input  wire logic                rstn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                sleepInstr,
    input  wire logic                watchdogTimeout,
    input  wire logic                extIntFlag,
    input  wire logic                portChangeFlag,
    input  wire logic [7:0]          periphFlag,
    input  wire logic [PORT_W-1:0]   portOutCore,
    input  wire logic [PORT_W-1:0]   portOeCore,
    output logic      [PORT_W-1:0]   portOut,
    output logic      [PORT_W-1:0]   portOe,
    output logic                     watchdogClear,
    output logic                     oscEnable,
    output logic                     phaseClockEnable,
    output logic                     prefetchNext,
    output logic                     coreStall,
    output logic                     resumeStrobe,
    output logic                     vectorTake,
    output logic      [12:0]         vectorAddr,
    output logic                     irq
);

    ////////////////////////////////////////////////////////////////////////
    // Registers and state

    swc_state_t  state;
    swc_state_t  next_state;
    logic [31:0] ctrl;
    logic [SWC_NSRC-1:0] wakeEn;
    logic        power_down_flag;
    logic        timeout_flag;
    logic [SWC_IRQ_W-1:0] irqStatus;
    logic [SWC_IRQ_W-1:0] irqMask;
    logic [PORT_W-1:0] heldOut;
    logic [PORT_W-1:0] heldOe;
    logic        wakeByInt;
    logic        restartDone;
    logic [31:0] next_rdata;
    logic        restartStart;

    swc_wake_if wk();

    ////////////////////////////////////////////////////////////////////////
    // Wake source gathering

    // Peripherals behind phaseClockEnable cannot flag while asleep, so only
    // the listed asynchronous ones are wired in as wake sources
    assign wk.flags   = {periphFlag, portChangeFlag, extIntFlag};
    assign wk.enables = wakeEn;

    swc_wake_sources u_src
    (
        .wk (wk.dst)
    );

    swc_restart_timer #(.CYCLES(SWC_RESTART_CYC)) u_restart
    (
        .clk   (clk),
        .rstn  (rstn),
        .start (restartStart),
        .done  (restartDone)
    );

    ////////////////////////////////////////////////////////////////////////
    // Decodes

    wire logic watchdogEn  = ctrl[SWC_CTL_WDTEN];
    wire logic gieBit      = ctrl[SWC_CTL_GIE];
    wire logic running     = (state == SWC_RUN);
    wire logic sleepNop    = running && sleepInstr && wk.pending;
    wire logic sleepTake   = running && sleepInstr && !wk.pending;
    wire logic asleep      = (state == SWC_SLEEP);
    wire logic wdtWake     = asleep && watchdogEn && watchdogTimeout;
    wire logic intWake     = asleep && wk.pending;
    wire logic anyWake     = wdtWake || intWake;
    assign restartStart    = anyWake;
    wire logic apbAccess   = psel && penable;
    wire logic apbWrite    = apbAccess && pwrite;
    wire logic apbRead     = apbAccess && !pwrite;
    wire logic selCtrl     = (paddr == SWC_OFF_CTRL);
    wire logic selStatus   = (paddr == SWC_OFF_STATUS);
    wire logic selWakeEn   = (paddr == SWC_OFF_WAKEEN);
    wire logic selIrqSt    = (paddr == SWC_OFF_IRQST);
    wire logic selIrqMsk   = (paddr == SWC_OFF_IRQMSK);
    wire logic selLatch    = (paddr == SWC_OFF_LATCH);
    wire logic mapped      = selCtrl | selStatus | selWakeEn | selIrqSt | selIrqMsk | selLatch;
    wire logic [SWC_IRQ_W-1:0] irqEvents = {sleepNop, anyWake, sleepTake};

    ////////////////////////////////////////////////////////////////////////
    // Sleep sequencer

    always_comb
    begin
        next_state = state;
        unique case (state)
            SWC_RUN:     if (sleepTake) next_state = SWC_SLEEP;
            SWC_SLEEP:   if (anyWake) next_state = SWC_RESTART;
            SWC_RESTART: if (restartDone) next_state = SWC_RESUME;
            SWC_RESUME:  next_state = SWC_RUN;
        endcase
    end

    // Master clear arrives on rstn: full reset, never a resume
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            state <= SWC_RUN;
        else
            state <= next_state;
    end

    // Remember wake cause for the vector decision
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            wakeByInt <= 1'b0;
        else if (anyWake)
            wakeByInt <= intWake;
    end

    ////////////////////////////////////////////////////////////////////////
    // Status flags: power-up sets both power_down_flag and timeout_flag

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            power_down_flag <= 1'b1;
            timeout_flag    <= 1'b1;
        end
        else if (sleepTake)
        begin
            power_down_flag <= 1'b0;
            timeout_flag    <= 1'b1;
        end
        else if (wdtWake && !intWake)
            timeout_flag <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Core-facing strobes

    assign watchdogClear    = sleepTake;
    assign prefetchNext     = running && sleepInstr;
    assign oscEnable        = !(asleep);
    assign phaseClockEnable = running || (state == SWC_RESUME);
    assign coreStall        = !running;
    assign resumeStrobe     = (state == SWC_RESUME);
    assign vectorTake       = resumeStrobe && wakeByInt && gieBit;
    assign vectorAddr       = SWC_INT_VECTOR;
    // Without global enable, resume simply continues after sleep
    assign irq              = |(irqStatus & irqMask);

    ////////////////////////////////////////////////////////////////////////
    // Port hold: snapshot taken on the entering edge

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            heldOut <= '0;
            heldOe  <= '0;
        end
        else if (sleepTake)
        begin
            heldOut <= portOutCore;
            heldOe  <= portOeCore;
        end
    end

    // Registered so a glitching core bus cannot leak to the pins in sleep
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            portOut <= '0;
            portOe  <= '0;
        end
        else
        begin
            portOut <= (asleep || sleepTake) ? ((sleepTake) ? portOutCore : heldOut) : portOutCore;
            portOe  <= (asleep || sleepTake) ? ((sleepTake) ? portOeCore : heldOe) : portOeCore;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software registers

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl    <= SWC_CTRL_RST;
            wakeEn  <= SWC_WAKEEN_RST[SWC_NSRC-1:0];
            irqMask <= '0;
        end
        else if (apbWrite)
        begin
            if (selCtrl)   ctrl    <= pwdata;
            if (selWakeEn) wakeEn  <= pwdata[SWC_NSRC-1:0];
            if (selIrqMsk) irqMask <= pwdata[SWC_IRQ_W-1:0];
        end
    end

    // Sticky events; a new event wins over the read-clear
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            irqStatus <= '0;
        else if (apbRead && selIrqSt)
            irqStatus <= irqEvents;
        else
            irqStatus <= irqStatus | irqEvents;
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux, zero-wait slave

    always_comb
    begin
        next_rdata = '0;
        if (selCtrl)   next_rdata = ctrl;
        if (selStatus)
        begin
            next_rdata[SWC_ST_ASLEEP] = !running;
            next_rdata[SWC_ST_GIE]    = gieBit;
            next_rdata[SWC_ST_PD]     = power_down_flag;
            next_rdata[SWC_ST_TO]     = timeout_flag;
        end
        if (selWakeEn) next_rdata[SWC_NSRC-1:0] = wakeEn;
        if (selIrqSt)  next_rdata[SWC_IRQ_W-1:0] = irqStatus;
        if (selIrqMsk) next_rdata[SWC_IRQ_W-1:0] = irqMask;
        if (selLatch)  next_rdata[SWC_NSRC-1:0] = wk.flags;
    end

    assign prdata  = apbRead ? next_rdata : '0;
    assign pready  = 1'b1;
    assign pslverr = apbAccess && !mapped;

endmodule

// File: sim/swc_monitor.sv
`timescale 1ns/1ps
module swc_monitor
    import swc_pkg::*;
#(
    parameter int PORT_W = 8
)
(
    input wire logic              clk,
    input wire logic              rstn,
    input wire logic              sleepInstr,
    input wire logic [PORT_W-1:0] portOut,
    input wire logic [PORT_W-1:0] portOe,
    input wire logic              watchdogClear,
    input wire logic              oscEnable,
    input wire logic              phaseClockEnable,
    input wire logic              prefetchNext,
    input wire logic              coreStall,
    input wire logic              resumeStrobe,
    input wire logic              vectorTake,
    input wire logic [12:0]       vectorAddr
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////
    // Entry side: only the strobe may start a sleep, and it stops the clocks
    a_clear_needs_sleep: assert property (watchdogClear |-> sleepInstr && prefetchNext)
        else $error("watchdog clear without sleep strobe");
    a_prefetch_on_sleep: assert property (prefetchNext |-> sleepInstr && !coreStall)
        else $error("prefetch without sleep in run");
    a_osc_off_after: assert property (watchdogClear |=> !oscEnable && coreStall)
        else $error("oscillator still on after sleep entry");
    a_pins_hold: assert property (!oscEnable && !$past(oscEnable) |-> $stable(portOut) && $stable(portOe))
        else $error("pin drive moved while asleep");
    a_no_phase_sleep: assert property (!oscEnable |-> !phaseClockEnable)
        else $error("phase clocks run while asleep");
    // Exit side: bounded restart, then resume with the fixed vector
    a_restart_bounded: assert property ($rose(oscEnable) |-> ##[0:12] resumeStrobe)
        else $error("restart did not finish in time");
    a_vector_fixed: assert property (vectorTake |-> resumeStrobe && vectorAddr == SWC_INT_VECTOR)
        else $error("vector taken badly");
    a_resume_runs: assert property (resumeStrobe |=> !coreStall && phaseClockEnable)
        else $error("core still stalled after resume");
endmodule

// File: sim/swc_core_model.sv
`timescale 1ns/1ps
module swc_core_model
(
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       goSleep,
    input  wire logic [9:0] srcSet,
    input  wire logic       wdFire,
    output logic            sleepInstr,
    output logic            watchdogTimeout,
    output logic            extIntFlag,
    output logic            portChangeFlag,
    output logic [7:0]      periphFlag,
    output logic [7:0]      portOutCore,
    output logic [7:0]      portOeCore
);
    ////////////////////////////////////////
    // Enables move too, so a pin that fails to freeze shows up
    assign portOeCore = ~portOutCore;
    // Core strobe, source flags and a drive pattern that never rests
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sleepInstr      <= 1'b0;
            watchdogTimeout <= 1'b0;
            {periphFlag, portChangeFlag, extIntFlag} <= '0;
            portOutCore     <= 8'h5A;
        end
        else
        begin
            sleepInstr      <= goSleep;
            watchdogTimeout <= wdFire;
            {periphFlag, portChangeFlag, extIntFlag} <= srcSet;
            portOutCore     <= portOutCore + 8'h01;
        end
    end
endmodule

// File: sim/testbench.sv
`timescale 1ns/1ps
module testbench
    import swc_pkg::*;
;
    logic        clk = '0, rstn = '0, psel = '0, penable = '0, pwrite = '0, goSleep = '0, wdFire = '0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [9:0]  srcSet = '0;
    logic        pready, pslverr, err, sleepInstr, watchdogTimeout, extIntFlag, portChangeFlag, watchdogClear;
    logic        oscEnable, phaseClockEnable, prefetchNext, coreStall, resumeStrobe, vectorTake, irq;
    logic [7:0]  periphFlag, portOutCore, portOeCore, portOut, portOe;
    logic [12:0] vectorAddr;
    int          errors = 0, check_count = 0;
    always #2 clk = ~clk;
    swc_sleep_wake_control i_swc_sleep_wake_control (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .sleepInstr, .watchdogTimeout, .extIntFlag, .portChangeFlag, .periphFlag,
        .portOutCore, .portOeCore, .portOut, .portOe, .watchdogClear, .oscEnable, .phaseClockEnable,
        .prefetchNext, .coreStall, .resumeStrobe, .vectorTake, .vectorAddr, .irq);
    swc_core_model i_swc_core_model (.clk, .rstn, .goSleep, .srcSet, .wdFire, .sleepInstr, .watchdogTimeout,
        .extIntFlag, .portChangeFlag, .periphFlag, .portOutCore, .portOeCore);
    ////////////////////////////////////////
    task automatic stop_test;
        $display("errors=%0d checks=%0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e)
        begin
            errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // One APB transfer; an idle edge follows so psel never toggles in one step
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        psel   <= 1'b1;
        paddr  <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
        if (n >= 20)
        begin
            errors++;
            stop_test();
        end
    endtask
    // Sleep strobe only; the bench runs no instruction after it
    task automatic nap;
        goSleep <= 1'b1;
        @(posedge clk);
        goSleep <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    // Bounded wait for the resume strobe
    task automatic wake;
        int n;
        n = 0;
        while (resumeStrobe !== 1'b1)
        begin
            @(posedge clk);
            n++;
            if (n > 40)
            begin
                errors++;
                stop_test();
            end
        end
    endtask
    ////////////////////////////////////////
    task automatic t_reset;
        apb(SWC_OFF_STATUS, 1'b0, '0);
        chk(rd, 32'h0000_0018);
        apb(12'h0FC, 1'b0, '0);
        chk(rd, 32'h0000_0000);
        chk({31'h0, err}, 32'h0000_0001);
    endtask
    task automatic t_nop;
        apb(SWC_OFF_WAKEEN, 1'b1, 32'h0000_0001);
        srcSet <= 10'h001;
        repeat (2) @(posedge clk);
        nap();
        chk(coreStall, 1'b0);
        apb(SWC_OFF_STATUS, 1'b0, '0);
        chk(rd, 32'h0000_0018);
        chk(irq, 1'b0);
        apb(SWC_OFF_IRQMSK, 1'b1, 32'h0000_0004);
        chk(irq, 1'b1);
        apb(SWC_OFF_IRQST, 1'b0, '0);
        chk(rd, 32'h0000_0004);
        chk(irq, 1'b0);
        srcSet <= '0;
    endtask
    // Every source: others pending but disabled must not wake
    task automatic t_sources;
        for (int i = 0; i < SWC_NSRC; i++)
        begin
            apb(SWC_OFF_WAKEEN, 1'b1, 32'h0000_0001 << i);
            nap();
            apb(SWC_OFF_STATUS, 1'b0, '0);
            chk(rd, 32'h0000_0011);
            srcSet <= ~(10'h001 << i);
            repeat (5) @(posedge clk);
            chk(coreStall, 1'b1);
            srcSet <= 10'h001 << i;
            wake();
            chk(vectorTake, 1'b0);
            srcSet <= '0;
            repeat (2) @(posedge clk);
        end
    endtask
    // Flag rises just after the strobe: sleep completes, then wakes
    task automatic t_gie;
        apb(SWC_OFF_CTRL, 1'b1, 32'h0000_0003);
        apb(SWC_OFF_WAKEEN, 1'b1, 32'h0000_0002);
        goSleep <= 1'b1;
        @(posedge clk);
        goSleep <= 1'b0;
        srcSet  <= 10'h002;
        wake();
        chk({vectorTake, vectorAddr}, 14'h2004);
        srcSet <= '0;
        apb(SWC_OFF_STATUS, 1'b0, '0);
        chk(rd, 32'h0000_0012);
    endtask
    task automatic t_watchdog;
        apb(SWC_OFF_CTRL, 1'b1, 32'h0000_0001);
        apb(SWC_OFF_WAKEEN, 1'b1, '0);
        nap();
        // Timeout only after the sleep entry has cleared the watchdog
        wdFire <= 1'b1;
        @(posedge clk);
        wdFire <= 1'b0;
        wake();
        chk(vectorTake, 1'b0);
        apb(SWC_OFF_STATUS, 1'b0, '0);
        chk(rd, 32'h0000_0000);
    endtask
    // Disabled watchdog is ignored; master clear resets from sleep
    task automatic t_master_clear_pin;
        apb(SWC_OFF_CTRL, 1'b1, '0);
        nap();
        wdFire <= 1'b1;
        repeat (20) @(posedge clk);
        chk(coreStall, 1'b1);
        wdFire <= 1'b0;
        rstn   <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        chk(coreStall, 1'b0);
        apb(SWC_OFF_STATUS, 1'b0, '0);
        chk(rd, 32'h0000_0018);
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_nop();
        t_sources();
        t_gie();
        t_watchdog();
        t_master_clear_pin();
        stop_test();
    end
endmodule
bind swc_sleep_wake_control swc_monitor #(.PORT_W(PORT_W)) i_swc_monitor (.clk, .rstn, .sleepInstr, .portOut, .portOe,
    .watchdogClear, .oscEnable, .phaseClockEnable, .prefetchNext, .coreStall, .resumeStrobe, .vectorTake, .vectorAddr);
